//--- lmc_ctrl.sv
// Decided for this implementation: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lmc_ctrl import lmc_pkg::*; #(
  parameter int unsigned DQW           = 32,
  parameter int unsigned POLL_CYC      = POLL_CYCLES,
  parameter int unsigned INITIAL_IMPEDANCE_CALIB_CK     = 64,
  parameter int unsigned IMPEDANCE_CALIB_RESET_CK    = 8,
  parameter int unsigned LONG_IMPEDANCE_CALIB_CK       = 32,
  parameter int unsigned SHORT_IMPEDANCE_CALIB_CK       = 16,
  parameter int unsigned RST_INIT_CK   = 128,
  parameter int unsigned RD_TIMEOUT_CK = 64,
  parameter logic [7:0]  CODE_INIT     = 8'h01,
  parameter logic [7:0]  CODE_RESET    = 8'h02,
  parameter logic [7:0]  CODE_LONG     = 8'h03,
  parameter logic [7:0]  CODE_SHORT    = 8'h04,
  parameter logic [7:0]  RESET_MA      = 8'h3F,
  parameter logic [7:0]  RESET_OP      = 8'h00
) (
  input  wire logic           aclk,
  input  wire logic           aresetn,
  input  wire logic [7:0]     s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [7:0]     s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire logic           banks_idle,
  input  wire logic [DQW-1:0] dq,
  input  wire logic           dq_strobe,
  output logic                cs_n,
  output logic [9:0]          ca_rise,
  output logic [9:0]          ca_fall,
  output logic                dq_quiet
);

  typedef struct packed {
    lmc_state_e     st;
    logic [31:0]    cnt;
    logic [31:0]    poll_cnt;
    logic [2:0]     beat;
    logic           init_pend;
    logic           poll_pend;
    logic           req_pend;
    logic           req_rd;
    logic           req_rst;
    logic           req_cal;
    logic [7:0]     req_ma;
    logic [7:0]     req_op;
    logic           cur_rd;
    logic           cur_rst;
    logic           cur_cal;
    logic [7:0]     cur_ma;
    logic [7:0]     cur_op;
    logic           cs_n;
    logic [9:0]     ca_rise;
    logic [9:0]     ca_fall;
    logic           quiet;
    logic           refused;
    logic           pat_ok;
    logic           init_done;
    logic           poll_en;
    logic [3:0]     pat;
    logic           lanes_ok;
    logic [7:0]     rdat;
    logic [7:0]     temp;
    logic [DQW-1:0] dq1;
    logic [DQW-1:0] dq2;
    logic           stb1;
    logic           stb2;
    logic           aw_got;
    logic           w_got;
    logic [7:0]     awaddr;
    logic [31:0]    wdata;
    logic [3:0]     wstrb;
    logic           bvalid;
    logic [1:0]     bresp;
    logic           rvalid;
    logic [31:0]    rdata;
    logic [1:0]     rresp;
  } lmc_regs_s;

  lmc_regs_s s;
  lmc_regs_s nx;

  // Rising half carries the opcode and upper address bits
  function automatic logic [9:0] ca_first(logic rd, logic [7:0] ma);
    return {ma[7:2], rd ? CA_MRR : CA_MRW};
  endfunction : ca_first

  function automatic logic [9:0] ca_second(logic [7:0] ma, logic [7:0] op);
    return {op, ma[1:0]};
  endfunction : ca_second

  function automatic logic [31:0] period(logic rst, logic cal,
                                         logic [7:0] op);
    logic [31:0] p;
    p = MRW_CK;
    if (rst)
      p = RST_INIT_CK;
    else if (cal) begin
      if (op == CODE_INIT)
        p = INITIAL_IMPEDANCE_CALIB_CK;
      else if (op == CODE_RESET)
        p = IMPEDANCE_CALIB_RESET_CK;
      else if (op == CODE_LONG)
        p = LONG_IMPEDANCE_CALIB_CK;
      else
        p = SHORT_IMPEDANCE_CALIB_CK;
    end
    return p;
  endfunction : period

  // Each lane: bit 0 follows lane 0, upper bits copy it or read zero
  function automatic logic lanes_good(logic [DQW-1:0] d);
    logic ok;
    ok = 1'b1;
    for (int l = 0; l < DQW / 8; l++) begin
      if (d[l*8] != d[0])
        ok = 1'b0;
      if (d[l*8+1 +: 7] != {7{d[0]}} && d[l*8+1 +: 7] != 7'h00)
        ok = 1'b0;
    end
    return ok;
  endfunction : lanes_good

  logic       aw_hs;
  logic       w_hs;
  logic       ar_hs;
  logic       go;
  logic       sel_rd;
  logic       sel_rst;
  logic       sel_cal;
  logic [7:0] sel_ma;
  logic [7:0] sel_op;
  logic       is_pat;

  assign s_axi_awready = !s.aw_got && !s.bvalid;
  assign s_axi_wready  = !s.w_got && !s.bvalid;
  assign s_axi_arready = !s.rvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;
  assign cs_n          = s.cs_n;
  assign ca_rise       = s.ca_rise;
  assign ca_fall       = s.ca_fall;
  assign dq_quiet      = s.quiet;
  assign aw_hs         = s_axi_awvalid && s_axi_awready;
  assign w_hs          = s_axi_wvalid && s_axi_wready;
  assign ar_hs         = s_axi_arvalid && s_axi_arready;
  assign is_pat        = s.cur_ma == MA_PAT_A || s.cur_ma == MA_PAT_B;

  always_comb begin
    nx      = s;
    go      = 1'b0;
    sel_rd  = 1'b0;
    sel_rst = 1'b0;
    sel_cal = 1'b0;
    sel_ma  = '0;
    sel_op  = '0;
    nx.dq1  = dq;
    nx.dq2  = s.dq1;
    nx.stb1 = dq_strobe;
    nx.stb2 = s.stb1;
    nx.cs_n = 1'b1;  // NOP whenever no command is issued
    nx.ca_rise = '0;
    nx.ca_fall = '0;

    // Temperature poll timer, sized against the 32 ms device update
    if (s.poll_en) begin
      if (s.poll_cnt >= POLL_CYC - 1) begin
        nx.poll_cnt  = '0;
        nx.poll_pend = 1'b1;
      end else
        nx.poll_cnt = s.poll_cnt + 32'd1;
    end

    if (aw_hs) begin
      nx.aw_got = 1'b1;
      nx.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      nx.w_got = 1'b1;
      nx.wdata = s_axi_wdata;
      nx.wstrb = s_axi_wstrb;
    end
    if (s.bvalid && s_axi_bready)
      nx.bvalid = 1'b0;
    if (s.aw_got && s.w_got && !s.bvalid) begin
      nx.aw_got = 1'b0;
      nx.w_got  = 1'b0;
      nx.bvalid = 1'b1;
      nx.bresp  = RESP_OKAY;
      unique case (s.awaddr)
        REG_CMD, REG_CALIB: begin
          // One command may wait; a second one is dropped
          if (s.req_pend)
            nx.refused = 1'b1;
          else if (s.awaddr == REG_CMD) begin
            nx.req_pend = 1'b1;
            nx.req_cal  = 1'b0;
            nx.req_rst  = s.wdata[CMD_RST_BIT];
            nx.req_rd   = s.wdata[CMD_RD_BIT] && !s.wdata[CMD_RST_BIT];
            nx.req_ma   = s.wdata[CMD_RST_BIT] ? RESET_MA : s.wdata[7:0];
            nx.req_op   = s.wdata[CMD_RST_BIT] ? RESET_OP : s.wdata[15:8];
          end else if (!s.init_done &&
                       (s.wdata[1:0] == CAL_LONG ||
                        s.wdata[1:0] == CAL_SHORT))
            nx.refused = 1'b1;
          else begin
            nx.req_pend = 1'b1;
            nx.req_cal  = 1'b1;
            nx.req_rst  = 1'b0;
            nx.req_rd   = 1'b0;
            nx.req_ma   = MA_CALIB;
            unique case (s.wdata[1:0])
              CAL_INIT:  nx.req_op = CODE_INIT;
              CAL_RESET: nx.req_op = CODE_RESET;
              CAL_LONG:  nx.req_op = CODE_LONG;
              default:   nx.req_op = CODE_SHORT;
            endcase
          end
        end
        REG_CONF:
          if (s.wstrb[0])
            nx.poll_en = s.wdata[0];
        REG_STAT:
          if (s.wstrb[0] && s.wdata[STAT_REFUSED])
            nx.refused = 1'b0;
        default:
          nx.bresp = RESP_SLVERR;
      endcase
    end

    if (s.rvalid && s_axi_rready)
      nx.rvalid = 1'b0;
    if (ar_hs) begin
      nx.rvalid = 1'b1;
      nx.rresp  = RESP_OKAY;
      nx.rdata  = '0;
      unique case (s_axi_araddr)
        REG_CMD:   nx.rdata = {14'h0000, s.req_rst, s.req_rd,
                               s.req_op, s.req_ma};
        REG_CALIB: nx.rdata = {24'h000000, s.req_op};
        REG_CONF:  nx.rdata = {31'h00000000, s.poll_en};
        REG_STAT:  nx.rdata = {27'h0000000, s.quiet, s.init_done,
                               s.pat_ok, s.refused,
                               s.st != ST_IDLE || s.req_pend};
        REG_RDATA: nx.rdata = {24'h000000, s.rdat};
        REG_TEMP:  nx.rdata = {24'h000000, s.temp};
        default:   nx.rresp = RESP_SLVERR;
      endcase
    end

    unique case (s.st)
      ST_IDLE: begin
        // Quiet also covers the gap cycle: the device counts one edge later
        nx.quiet = 1'b0;
        if (s.init_pend) begin
          // Initial calibration runs first after reset
          if (banks_idle) begin
            go           = 1'b1;
            sel_cal      = 1'b1;
            sel_ma       = MA_CALIB;
            sel_op       = CODE_INIT;
            nx.init_pend = 1'b0;
          end
        end else if (s.req_pend) begin
          nx.req_pend = 1'b0;
          // Plain reads are allowed with banks open
          if (!banks_idle && (!s.req_rd || s.req_ma == MA_PAT_A ||
                              s.req_ma == MA_PAT_B))
            nx.refused = 1'b1;
          else begin
            go      = 1'b1;
            sel_rd  = s.req_rd;
            sel_rst = s.req_rst;
            sel_cal = s.req_cal;
            sel_ma  = s.req_ma;
            sel_op  = s.req_op;
          end
        end else if (s.poll_pend) begin
          nx.poll_pend = 1'b0;
          go           = 1'b1;
          sel_rd       = 1'b1;
          sel_ma       = MA_TEMP;
        end
        if (go) begin
          nx.cs_n    = 1'b0;
          nx.ca_rise = ca_first(sel_rd, sel_ma);
          nx.ca_fall = ca_second(sel_ma, sel_rd ? 8'h00 : sel_op);
          nx.cur_rd  = sel_rd;
          nx.cur_rst = sel_rst;
          nx.cur_cal = sel_cal;
          nx.cur_ma  = sel_ma;
          nx.cur_op  = sel_op;
          nx.quiet   = sel_cal;
          nx.beat    = '0;
          nx.lanes_ok = 1'b1;
          nx.pat     = '0;
          if (sel_rd) begin
            nx.st  = ST_READ;
            nx.cnt = '0;
          end else begin
            nx.st  = ST_WAIT;
            nx.cnt = period(sel_rst, sel_cal, sel_op) - 32'd1;
          end
        end
      end
      ST_WAIT: begin
        // Only NOPs until the period ends
        if (s.cnt <= 32'd1) begin
          nx.st    = ST_IDLE;
          if (s.cur_cal && s.cur_op == CODE_INIT)
            nx.init_done = 1'b1;
          if (s.cur_rst) begin
            nx.init_done = 1'b0;
            nx.init_pend = 1'b1;
          end
        end else
          nx.cnt = s.cnt - 32'd1;
      end
      ST_READ: begin
        nx.cnt = s.cnt + 32'd1;
        // Extra strobes past the fourth are ignored
        if (s.stb2 && s.beat < 3'(BURST_BEATS)) begin
          nx.beat = s.beat + 3'd1;
          nx.pat[s.beat[1:0]] = s.dq2[0];
          if (!lanes_good(s.dq2))
            nx.lanes_ok = 1'b0;
          if (s.beat == 3'd0) begin
            nx.rdat = s.dq2[7:0];
            if (s.cur_ma == MA_TEMP)
              nx.temp = s.dq2[7:0];
          end
        end
        if (s.beat == 3'(BURST_BEATS) && s.cnt >= MRR_CK - 1) begin
          nx.st = ST_IDLE;
          if (is_pat)
            nx.pat_ok = s.lanes_ok && s.pat ==
              (s.cur_ma == MA_PAT_A ? PAT_A : PAT_B);
        end else if (s.cnt >= RD_TIMEOUT_CK) begin
          nx.st      = ST_IDLE;
          nx.refused = 1'b1;
        end
      end
      default: nx.st = ST_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s           <= '0;
      s.cs_n      <= 1'b1;
      s.poll_en   <= POLL_EN_RST;
      s.init_pend <= 1'b1;
    end else
      s <= nx;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_mrw_banks_idle: assert property (
    !s.cs_n && !s.cur_rd |-> $past(banks_idle))
    else $error("mode write issued with banks active");
  a_pat_read_idle: assert property (
    !s.cs_n && s.cur_rd && is_pat |-> $past(banks_idle))
    else $error("pattern read issued with banks active");
  a_write_nop_gap: assert property (
    !s.cs_n && !s.cur_rd |=> s.cs_n [*4])
    else $error("command issued inside mode write period");
  a_read_nop_gap: assert property (
    !s.cs_n && s.cur_rd |=> s.cs_n)
    else $error("command issued inside mode read period");
  a_read_opcode: assert property (
    !s.cs_n && s.cur_rd |-> s.ca_rise[3:0] == 4'h8 && s.st == ST_READ)
    else $error("read opcode wrong on rising half");
  a_write_addr: assert property (
    !s.cs_n |-> s.ca_rise[9:4] == s.cur_ma[7:2] &&
                s.ca_fall[1:0] == s.cur_ma[1:0] &&
                (s.cur_rd || s.ca_rise[3:0] == 4'h0))
    else $error("register address split wrong");
  a_write_data: assert property (
    !s.cs_n && !s.cur_rd |-> s.ca_fall[9:2] == s.cur_op)
    else $error("write data not on falling half");
  a_calib_target: assert property (
    !s.cs_n && s.cur_cal |-> s.cur_ma == 8'h0A ##1 s.quiet)
    else $error("calibration not aimed at register 0Ah");
  a_calib_quiet: assert property (
    s.st == ST_WAIT && s.cur_cal |-> dq_quiet)
    else $error("data bus not held quiet in calibration");
  a_init_first: assert property (
    !s.cs_n && s.cur_cal &&
    (s.cur_op == CODE_LONG || s.cur_op == CODE_SHORT) |-> s.init_done)
    else $error("long or short calibration before initial one");
  a_burst_four: assert property (
    s.st == ST_READ && nx.st == ST_IDLE && s.cnt < RD_TIMEOUT_CK
    |-> s.beat == 3'd4)
    else $error("read closed before four beats");

  c_mode_write: cover property (!s.cs_n && !s.cur_rd && !s.cur_cal);
  c_pat_ok: cover property ($rose(s.pat_ok));
  c_init_done: cover property ($rose(s.init_done));
  c_temp_poll: cover property (!s.cs_n && s.cur_ma == MA_TEMP);
  c_refused: cover property ($rose(s.refused));

endmodule : lmc_ctrl
`default_nettype wire

//--- lmc_pkg.sv
package lmc_pkg;
  // Clock and timing
  localparam int unsigned CLK_NS      = 100;
  localparam int unsigned MRR_CK      = 2;    // mode_read_period, cycles
  localparam int unsigned MRW_CK      = 5;    // mode_write_period, cycles
  localparam int unsigned TSI_MS      = 32;   // temp_update_interval
  localparam int unsigned POLL_MS     = 167;
  localparam int unsigned POLL_CYCLES = POLL_MS * (1000000 / CLK_NS);
  localparam int unsigned BURST_BEATS = 4;

  // Mode register addresses and command codes
  localparam logic [7:0] MA_TEMP   = 8'h04;   // temp_status_reg
  localparam logic [7:0] MA_PAT_A  = 8'h20;   // calib_pattern_a_reg
  localparam logic [7:0] MA_PAT_B  = 8'h28;   // calib_pattern_b_reg
  localparam logic [7:0] MA_CALIB  = 8'h0A;   // impedance_calib_reg
  localparam logic [3:0] CA_MRW    = 4'h0;
  localparam logic [3:0] CA_MRR    = 4'h8;
  // Beat n of the pattern sits in bit n
  localparam logic [3:0] PAT_A     = 4'h5;
  localparam logic [3:0] PAT_B     = 4'hC;

  // Software register map
  localparam logic [7:0] REG_CMD   = 8'h00;
  localparam logic [7:0] REG_CALIB = 8'h04;
  localparam logic [7:0] REG_CONF  = 8'h08;
  localparam logic [7:0] REG_STAT  = 8'h0C;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_TEMP  = 8'h14;
  localparam int unsigned CMD_RD_BIT   = 16;
  localparam int unsigned CMD_RST_BIT  = 17;
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_REFUSED = 1;
  localparam int unsigned STAT_PAT_OK  = 2;
  localparam int unsigned STAT_INIT    = 3;
  localparam int unsigned STAT_QUIET   = 4;
  localparam logic        POLL_EN_RST  = 1'b1;
  localparam logic [1:0]  RESP_OKAY    = 2'b00;
  localparam logic [1:0]  RESP_SLVERR  = 2'b10;

  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_READ} lmc_state_e;
  typedef enum logic [1:0] {CAL_INIT, CAL_RESET, CAL_LONG, CAL_SHORT}
    lmc_cal_e;
endpackage : lmc_pkg

//--- lmc_dev_model.sv
`timescale 1ns/1ps
`default_nettype none
module lmc_dev_model import lmc_pkg::*; #(
  parameter int unsigned DQW     = 32,
  parameter int unsigned RL      = 3,
  parameter int unsigned SLOW_RL = 11,
  // Scaled down from the real update interval to keep runs short
  parameter int unsigned TSI_CK  = 3200,
  parameter logic [7:0]  TEMP    = 8'h03,
  parameter int unsigned ZQI_CK  = 64,
  parameter int unsigned ZQR_CK  = 8,
  parameter int unsigned ZQL_CK  = 32,
  parameter int unsigned ZQS_CK  = 16,
  parameter int unsigned RST_CK  = 128,
  parameter bit          COPY    = 1'b1,
  parameter bit          ZQ_TIED = 1'b0
) (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       cs_n,
  input  wire logic [9:0] ca_rise,
  input  wire logic [9:0] ca_fall,
  input  wire logic       dq_quiet,
  input  wire logic       banks_idle,
  input  wire logic [1:0] mode,
  output logic [DQW-1:0]  dq,
  output logic            dq_strobe,
  output logic [7:0]      last_ma,
  output logic [7:0]      last_op,
  output int              n_cmd,
  output int              errs
);
  logic [7:0]     mr [256];
  logic [7:0]     ma, op, rd_ma, temp_q, lane;
  logic [3:0]     pat;
  logic           b;
  logic [DQW-1:0] beat_v;
  int             tsi, busy, cal, lat, beat, per;
  bit             rd_on;
  assign ma = {ca_rise[9:4], ca_fall[1:0]};
  assign op = ca_fall[9:2];
  always_comb begin
    pat = (rd_ma == 8'h20) ? 4'h5 : 4'hC;
    b = pat[beat[1:0]];
    lane = COPY ? {8{b}} : {7'h00, b};
    beat_v = {(DQW / 8){lane}};
    // Mode 2 breaks lane 1 so the pattern check can be seen to fail
    if (mode == 2'd2) beat_v[8] = ~b;
    if (rd_ma != 8'h20 && rd_ma != 8'h28)
      beat_v = {{(DQW - 8){b}}, (rd_ma == 8'h04) ? temp_q : mr[rd_ma]};
    case (op)
      8'h01: per = ZQI_CK;
      8'h02: per = ZQR_CK;
      8'h03: per = ZQL_CK;
      default: per = ZQS_CK;
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 256; i++) mr[i] <= 8'h00;
      {busy, cal, tsi, lat, beat, n_cmd, errs} <= '0;
      rd_on <= 1'b0;
      dq <= '0;
      dq_strobe <= 1'b0;
      temp_q <= TEMP;
      last_ma <= 8'h00;
      last_op <= 8'h00;
      rd_ma <= 8'h00;
    end else begin
      tsi <= (tsi >= TSI_CK - 1) ? 0 : tsi + 1;
      if (tsi == 0) temp_q <= TEMP;
      busy <= (busy != 0) ? busy - 1 : 0;
      cal <= (cal != 0) ? cal - 1 : 0;
      if (cal != 0 && dq_quiet !== 1'b1) errs <= errs + 1;
      // Released bus shows the inverse of its last value, never a hold
      dq <= ~dq;
      dq_strobe <= 1'b0;
      if (rd_on && lat != 0) lat <= lat - 1;
      if (rd_on && lat == 0) begin
        dq <= beat_v;
        dq_strobe <= 1'b1;
        beat <= beat + 1;
        rd_on <= (beat != 3);
      end
      if (cs_n === 1'b0) begin
        n_cmd <= n_cmd + 1;
        last_ma <= ma;
        last_op <= op;
        if (busy != 0 || rd_on || (ca_rise[3:0] != 4'h0
            && ca_rise[3:0] != 4'h8)) errs <= errs + 1;
        if (ca_rise[3:0] == 4'h0) begin
          if (!banks_idle) errs <= errs + 1;
          busy <= MRW_CK - 1;
          if (ma == 8'h3F && op == 8'h00) begin
            for (int i = 0; i < 256; i++) mr[i] <= 8'h00;
            busy <= RST_CK - 1;
          end else if (ma == 8'h0A) begin
            busy <= per - 1;
            if (!ZQ_TIED) cal <= per - 1;
          end else if (ma != 8'h04 && ma != 8'h20 && ma != 8'h28)
            mr[ma] <= op;
        end else if (ca_rise[3:0] == 4'h8) begin
          if (!banks_idle && (ma == 8'h20 || ma == 8'h28))
            errs <= errs + 1;
          busy <= MRR_CK - 1;
          rd_on <= (mode != 2'd3);
          lat <= (mode == 2'd1) ? SLOW_RL : RL;
          beat <= 0;
          rd_ma <= ma;
        end
      end
    end
  end
endmodule : lmc_dev_model
`default_nettype wire

//--- tb_lmc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin \
  n_checks++; \
  if ((g) !== (e)) begin \
    bad_count++; \
    $display("BAD %s exp %0h got %0h", nm, (e), (g)); \
  end \
end
module tb_lmc_ctrl import lmc_pkg::*; ();
  localparam int unsigned POLL = 200;
  localparam logic [7:0]  TEMP = 8'h06;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        banks_idle = 1'b1;
  logic [1:0]  mode = 2'd0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, cs_n, dq_quiet, dq_strobe;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, dq, d;
  logic [9:0]  ca_rise, ca_fall;
  logic [7:0]  last_ma, last_op;
  logic [7:0]  ba [3];
  logic [31:0] bv [3];
  int          n_cmd, errs, n0, bad_count, n_checks;

  lmc_ctrl #(.POLL_CYC(POLL)) lmc_ctrl_inst (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .banks_idle, .dq, .dq_strobe, .cs_n,
    .ca_rise, .ca_fall, .dq_quiet
  );
  lmc_dev_model #(.TEMP(TEMP)) lmc_dev_model_inst (
    .aclk, .aresetn, .cs_n, .ca_rise, .ca_fall, .dq_quiet, .banks_idle,
    .mode, .dq, .dq_strobe, .last_ma, .last_op, .n_cmd, .errs
  );

  always #50 aclk = ~aclk;

  task automatic end_of_test;
    $display("checks %0d bad %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  // Ready and response are sampled mid-cycle, where they have settled
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    bit ah = 1'b0;
    bit wh = 1'b0;
    bit x;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ah && wh)) begin
      @(negedge aclk);
      ah = ah || (s_axi_awvalid && s_axi_awready);
      wh = wh || (s_axi_wvalid && s_axi_wready);
      @(posedge aclk);
      if (ah) s_axi_awvalid <= 1'b0;
      if (wh) s_axi_wvalid <= 1'b0;
    end
    do begin
      @(negedge aclk);
      x = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
    end while (!x);
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    bit x;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(negedge aclk);
      x = s_axi_arready;
      @(posedge aclk);
    end while (!x);
    s_axi_arvalid <= 1'b0;
    do begin
      @(negedge aclk);
      x = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
    end while (!x);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Leaves the final status word in d
  task automatic idle;
    repeat (4) @(posedge aclk);
    do rd(REG_STAT); while (d[STAT_BUSY] !== 1'b0);
  endtask : idle

  task automatic cmd(input logic [31:0] v);
    wr(REG_CMD, v);
    idle();
  endtask : cmd

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
  end

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    end_of_test();
  end

  initial begin
    ba = '{REG_CMD, REG_CALIB, REG_CMD};
    bv = '{32'h00005503, 32'h00000003, 32'h00010020};
    repeat (11) @(posedge aclk);
    rd(REG_CONF);
    `CHK("conf_rst", 1'b1, d[0])
    wr(REG_CONF, 32'h0);
    rd(8'h18);
    `CHK("rresp", RESP_SLVERR, r)
    `CHK("rdata", 32'h0, d)
    wr(8'h18, 32'h1);
    `CHK("bresp", RESP_SLVERR, r)
    do rd(REG_STAT); while (d[STAT_INIT] !== 1'b1);
    `CHK("init_ma", 8'h0A, last_ma)
    `CHK("init_op", 8'h01, last_op)
    cmd(32'h0000C303);
    `CHK("mrw_ma", 8'h03, last_ma)
    `CHK("mrw_op", 8'hC3, last_op)
    cmd(32'h00005A04);
    cmd(32'h00010004);
    rd(REG_RDATA);
    `CHK("ro_reg", TEMP, d[7:0])
    cmd(32'h00010003);
    rd(REG_RDATA);
    `CHK("mr_back", 8'hC3, d[7:0])
    for (int m = 0; m < 3; m++) begin
      for (int p = 0; p < 2; p++) begin
        mode <= m[1:0];
        cmd(p ? 32'h00010028 : 32'h00010020);
        `CHK("pat_ok", m != 2, d[STAT_PAT_OK])
        rd(REG_RDATA);
        if (m != 2) `CHK("beat0", p ? 8'h00 : 8'hFF, d[7:0])
      end
    end
    mode <= 2'd3;
    cmd(32'h00010020);
    `CHK("rd_timeout", 1'b1, d[STAT_REFUSED])
    mode <= 2'd0;
    wr(REG_STAT, 32'h2);
    rd(REG_STAT);
    `CHK("refused_clr", 1'b0, d[STAT_REFUSED])
    n0 = n_cmd;
    wr(REG_CALIB, 32'h2);
    wr(REG_CMD, 32'h00007711);
    wr(REG_CMD, 32'h00001122);
    while (n_cmd != n0 + 2) @(posedge aclk);
    idle();
    `CHK("queue_refuse", 1'b1, d[STAT_REFUSED])
    `CHK("queue_ma", 8'h11, last_ma)
    `CHK("queue_op", 8'h77, last_op)
    wr(REG_STAT, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(REG_CALIB, 32'(i));
      idle();
      `CHK("cal_code", 8'(i + 1), last_op)
    end
    banks_idle <= 1'b0;
    n0 = n_cmd;
    for (int i = 0; i < 3; i++) begin
      wr(ba[i], bv[i]);
      idle();
      `CHK("bank_refuse", 1'b1, d[STAT_REFUSED])
      wr(REG_STAT, 32'h2);
    end
    `CHK("bank_cmds", n0, n_cmd)
    cmd(32'h00010003);
    rd(REG_RDATA);
    `CHK("bank_read", 8'hC3, d[7:0])
    banks_idle <= 1'b1;
    n0 = n_cmd;
    wr(REG_CMD, 32'h00020000);
    while (n_cmd != n0 + 2) @(posedge aclk);
    idle();
    `CHK("rst_init", 8'h01, last_op)
    cmd(32'h00010003);
    rd(REG_RDATA);
    `CHK("rst_dflt", 8'h00, d[7:0])
    wr(REG_CONF, 32'h1);
    repeat (3 * POLL) @(posedge aclk);
    rd(REG_TEMP);
    `CHK("temp", TEMP, d[7:0])
    `CHK("link_errs", 0, errs)
    end_of_test();
  end
endmodule : tb_lmc_ctrl
`default_nettype wire
